/* File: gpgc_pkg.sv */
// Purpose: constants and types shared by the port global control block.
// Assumes: 250 MHz core clock; register access port from the serial-bus front end.
// Notes: every offset, reset value, field position and cycle count lives here.
// Summary of operation
// - column value bit 0 drives pin low, 1 drives high; upper four release open-drain
// - level-shift bit n couples column n and row n; direction from column direction
// - timeout interrupt enable raises interrupt on bus timeout; flag read drops it
// - port enable cleared stops pwm, current sinks and port inputs
// - port enable cleared leaves configured outputs driving their programmed levels
// - port enable cleared: registers 0x31 to 0x5b except global config 0x40 hold and ignore writes
// - port enable cleared while key scanner sleeps shuts the whole device down
// - port enable set keeps pwm, sinks and pins running regardless of sleep
// - writing port reset returns registers 0x31 to 0x5b to power-on values
// - port reset bit is a pulse and reads back as zero
// - fade codes 001 to 101 ramp between common pwm and zero in 16 steps
// - fade code 001 is 256 ms, doubling per code to 4096 ms at 101
// - debounce 9 ms at field zero, 40 ms at all ones
// - each debounce field step adds one millisecond; upper three bits reserved
// - upper four columns always open-drain; their output-mode bits ignore writes
package gpgc_pkg;
    localparam logic [7:0] ADDR_RANGE_LO = 8'h31;
    localparam logic [7:0] ADDR_RANGE_HI = 8'h5b;
    localparam logic [7:0] ADDR_COL_VALUES = 8'h3b;
    localparam logic [7:0] ADDR_SHIFT_EN = 8'h3c;
    localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h40;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h42;
    localparam logic [7:0] ADDR_TMO_FLAG = 8'h48;
    localparam logic [7:0] RST_COL_VALUES = 8'hff;
    localparam logic [7:0] RST_SHIFT_EN = 8'h00;
    localparam logic [7:0] RST_GLOBAL_CFG = 8'h00;
    localparam logic [7:0] RST_DEBOUNCE = 8'h00;
    localparam int CFG_TMO_IE_BIT = 5;
    localparam int CFG_PORT_EN_BIT = 4;
    localparam int CFG_PORT_RST_BIT = 3;
    localparam int CFG_FADE_LSB = 0;
    localparam int DBNC_WIDTH = 5;
    localparam int UPPER_COL_LSB = 4;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_TIME_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_TIME_NS / CLK_PERIOD_NS;
    localparam logic [5:0] DBNC_BASE_MS = 6'h09;
    localparam logic [2:0] FADE_OFF = 3'h0;
    localparam logic [2:0] FADE_MAX_CODE = 3'h5;
    localparam logic [8:0] FADE_STEP_BASE_MS = 9'h010;
    localparam logic [4:0] FADE_STEPS = 5'h10;

    typedef struct packed {
        logic [7:0] col_val;
        logic [7:0] shift_en;
        logic tmo_ie;
        logic port_en;
        logic [2:0] fade;
        logic [4:0] dbnc;
        logic tmo_flag;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] col_out;
        logic [7:0] col_oe;
        logic [7:0] row_out;
        logic [7:0] row_oe;
        logic run;
        logic shutdown;
        logic port_rst;
        logic [17:0] ms_cnt;
        logic ms_tick;
    } gpgc_top_s;
endpackage

/* File: gpgc_fade_if.sv */
// Purpose: carries fade control and result between top and fade engine.
// Assumes: one clock domain.
// Notes: level is the faded pwm intensity.
interface gpgc_fade_if;
    import gpgc_pkg::*;
    logic ms_tick;
    logic run;
    logic [2:0] code;
    logic [7:0] common_pwm;
    logic target_on;
    logic [7:0] level;
    modport ctrl (output ms_tick, output run, output code, output common_pwm,
                  output target_on, input level);
    modport engine (input ms_tick, input run, input code, input common_pwm,
                    input target_on, output level);
endinterface

/* File: gpgc_fade.sv */
// Purpose: ramps pwm intensity between zero and the common value.
// Assumes: ms_tick is a one-cycle pulse each millisecond.
// Notes: undefined codes behave as no fading.
module gpgc_fade
    import gpgc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    gpgc_fade_if.engine f
);
    typedef struct packed {
        logic [4:0] step;
        logic [8:0] cnt;
        logic [7:0] level;
    } gpgc_fade_s;

    gpgc_fade_s q;
    gpgc_fade_s next_q;
    logic [8:0] step_ms;
    logic [12:0] prod;
    logic fading;

    always_comb begin
        next_q = q;
        fading = (f.code != FADE_OFF) && (f.code <= FADE_MAX_CODE);
        step_ms = fading ? 9'(FADE_STEP_BASE_MS << (f.code - 3'h1)) : 9'h001;
        if (!f.run) begin
            next_q.step = 5'h00;
            next_q.cnt = 9'h000;
        end else if (!fading) begin
            next_q.step = f.target_on ? FADE_STEPS : 5'h00;
            next_q.cnt = 9'h000;
        end else if (f.ms_tick) begin
            if (q.cnt >= step_ms - 9'h001) begin
                next_q.cnt = 9'h000;
                if (f.target_on && q.step < FADE_STEPS) begin
                    next_q.step = q.step + 5'h01;
                end else if (!f.target_on && q.step != 5'h00) begin
                    next_q.step = q.step - 5'h01;
                end
            end else begin
                next_q.cnt = q.cnt + 9'h001;
            end
        end
        prod = f.common_pwm * next_q.step;
        next_q.level = (next_q.step == FADE_STEPS) ? f.common_pwm : prod[11:4];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign f.level = q.level;
endmodule

/* File: gpgc_debounce.sv */
// Purpose: debounces one port input over a millisecond count.
// Assumes: din synchronous to clk; ms_tick one-cycle pulse.
// Notes: output held while run is low.
module gpgc_debounce
    import gpgc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic ms_tick,
    input wire logic [5:0] limit_ms,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic [5:0] cnt;
        logic state;
    } gpgc_dbnc_s;

    gpgc_dbnc_s q;
    gpgc_dbnc_s next_q;

    always_comb begin
        next_q = q;
        if (!run) begin
            next_q.cnt = 6'h00;
        end else if (din == q.state) begin
            next_q.cnt = 6'h00;
        end else if (ms_tick) begin
            if (q.cnt >= limit_ms - 6'h01) begin
                next_q.state = din;
                next_q.cnt = 6'h00;
            end else begin
                next_q.cnt = q.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.state;
endmodule

/* File: gpgc_top.sv */
// Purpose: port global control: column values, level shifting, enable, reset, fade, debounce.
// Assumes: register access port decoded by the serial-bus front end; pins synchronous.
// Notes: outputs of this module all come from flip-flops.
module gpgc_top
    import gpgc_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic BUS_TIMEOUT,
    input wire logic SLEEP_MODE,
    input wire logic [7:0] COMMON_PWM,
    input wire logic FADE_TARGET_ON,
    input wire logic [7:0] COL_DIR_OUT,
    input wire logic [7:0] COL_PUSH_PULL,
    input wire logic [7:0] COL_IN,
    output logic [7:0] COL_OUT,
    output logic [7:0] COL_OE,
    input wire logic [7:0] ROW_IN,
    output logic [7:0] ROW_OUT,
    output logic [7:0] ROW_OE,
    output logic [7:0] PORT_INPUT,
    output logic [7:0] FADE_LEVEL,
    output logic TIMEOUT_IRQ,
    output logic PORT_RUN,
    output logic DEVICE_SHUTDOWN,
    output logic PORT_REG_RESET
);
    gpgc_top_s q;
    gpgc_top_s next_q;
    logic in_range;
    logic wr_ok;
    logic rd_flag;
    logic port_rst_req;
    logic [7:0] col_drive;
    logic [7:0] open_drain;
    logic [5:0] dbnc_limit;

    gpgc_fade_if fade_bus ();

    always_comb begin
        next_q = q;
        next_q.port_rst = 1'b0;
        in_range = (REG_ADDR >= ADDR_RANGE_LO) && (REG_ADDR <= ADDR_RANGE_HI);
        // global config stays writable so the section can be re-enabled
        wr_ok = REG_WR && (!in_range || q.port_en || REG_ADDR == ADDR_GLOBAL_CFG);
        rd_flag = REG_RD && (REG_ADDR == ADDR_TMO_FLAG);
        port_rst_req = REG_WR && (REG_ADDR == ADDR_GLOBAL_CFG)
            && REG_WDATA[CFG_PORT_RST_BIT];

        // millisecond enable divider
        next_q.ms_tick = 1'b0;
        if (q.ms_cnt == 18'(MS_CYCLES - 1)) begin
            next_q.ms_cnt = 18'h00000;
            next_q.ms_tick = 1'b1;
        end else begin
            next_q.ms_cnt = q.ms_cnt + 18'h00001;
        end

        // register writes
        if (wr_ok) begin
            if (REG_ADDR == ADDR_COL_VALUES) begin
                next_q.col_val = REG_WDATA;
            end else if (REG_ADDR == ADDR_SHIFT_EN) begin
                next_q.shift_en = REG_WDATA;
            end else if (REG_ADDR == ADDR_GLOBAL_CFG) begin
                next_q.tmo_ie = REG_WDATA[CFG_TMO_IE_BIT];
                next_q.port_en = REG_WDATA[CFG_PORT_EN_BIT];
                next_q.fade = REG_WDATA[CFG_FADE_LSB +: 3];
            end else if (REG_ADDR == ADDR_DEBOUNCE) begin
                next_q.dbnc = REG_WDATA[DBNC_WIDTH-1:0];
            end
        end

        // timeout flag: read clears, new timeout wins
        if (rd_flag) begin
            next_q.tmo_flag = 1'b0;
        end
        if (port_rst_req) begin
            next_q.col_val = RST_COL_VALUES;
            next_q.shift_en = RST_SHIFT_EN;
            next_q.tmo_ie = RST_GLOBAL_CFG[CFG_TMO_IE_BIT];
            next_q.port_en = RST_GLOBAL_CFG[CFG_PORT_EN_BIT];
            next_q.fade = RST_GLOBAL_CFG[CFG_FADE_LSB +: 3];
            next_q.dbnc = RST_DEBOUNCE[DBNC_WIDTH-1:0];
            next_q.tmo_flag = 1'b0;
            next_q.port_rst = 1'b1;
        end
        if (BUS_TIMEOUT && q.tmo_ie) begin
            next_q.tmo_flag = 1'b1;
        end
        next_q.irq = next_q.tmo_flag && next_q.tmo_ie;

        // read data
        next_q.rdata = q.rdata;
        if (REG_RD) begin
            if (REG_ADDR == ADDR_COL_VALUES) begin
                next_q.rdata = q.col_val;
            end else if (REG_ADDR == ADDR_SHIFT_EN) begin
                next_q.rdata = q.shift_en;
            end else if (REG_ADDR == ADDR_GLOBAL_CFG) begin
                // reset bit always reads zero
                next_q.rdata = {2'b00, q.tmo_ie, q.port_en, 1'b0, q.fade};
            end else if (REG_ADDR == ADDR_DEBOUNCE) begin
                next_q.rdata = {3'b000, q.dbnc};
            end else if (REG_ADDR == ADDR_TMO_FLAG) begin
                next_q.rdata = {7'h00, q.tmo_flag};
            end else begin
                next_q.rdata = 8'h00;
            end
        end

        // power state
        next_q.run = q.port_en;
        next_q.shutdown = !q.port_en && SLEEP_MODE;

        // pin drive, independent of port enable
        open_drain = ~{4'h0, COL_PUSH_PULL[UPPER_COL_LSB-1:0]};
        for (int n = 0; n < 8; n++) begin
            col_drive[n] = q.shift_en[n] ? ROW_IN[n] : q.col_val[n];
            if (!COL_DIR_OUT[n]) begin
                next_q.col_out[n] = 1'b0;
                next_q.col_oe[n] = 1'b0;
            end else if (open_drain[n]) begin
                next_q.col_out[n] = 1'b0;
                next_q.col_oe[n] = !col_drive[n];
            end else begin
                next_q.col_out[n] = col_drive[n];
                next_q.col_oe[n] = 1'b1;
            end
            next_q.row_oe[n] = q.shift_en[n] && !COL_DIR_OUT[n];
            next_q.row_out[n] = next_q.row_oe[n] && COL_IN[n];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= '0;
            q.col_val <= RST_COL_VALUES;
            q.shift_en <= RST_SHIFT_EN;
            q.dbnc <= RST_DEBOUNCE[DBNC_WIDTH-1:0];
        end else begin
            q <= next_q;
        end
    end

    assign fade_bus.ms_tick = q.ms_tick;
    assign fade_bus.run = q.run;
    assign fade_bus.code = q.fade;
    assign fade_bus.common_pwm = COMMON_PWM;
    assign fade_bus.target_on = FADE_TARGET_ON;

    gpgc_fade u_fade (
        .clk(CLK),
        .arst_n(ARST_N),
        .f(fade_bus)
    );

    assign dbnc_limit = DBNC_BASE_MS + {1'b0, q.dbnc};

    for (genvar g = 0; g < 8; g++) begin : g_dbnc
        gpgc_debounce u_dbnc (
            .clk(CLK),
            .arst_n(ARST_N),
            .run(q.run),
            .ms_tick(q.ms_tick),
            .limit_ms(dbnc_limit),
            .din(COL_IN[g]),
            .dout(PORT_INPUT[g])
        );
    end

    assign REG_RDATA = q.rdata;
    assign COL_OUT = q.col_out;
    assign COL_OE = q.col_oe;
    assign ROW_OUT = q.row_out;
    assign ROW_OE = q.row_oe;
    assign FADE_LEVEL = fade_bus.level;
    assign TIMEOUT_IRQ = q.irq;
    assign PORT_RUN = q.run;
    assign DEVICE_SHUTDOWN = q.shutdown;
    assign PORT_REG_RESET = q.port_rst;
endmodule

/* File: gpgc_checker.sv */
// Purpose: pin-level checks of port global control.
// Assumes: one clock; MS_CYCLES small in simulation.
// Notes: sees top ports only.
module gpgc_checker
    import gpgc_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic BUS_TIMEOUT,
    input wire logic SLEEP_MODE,
    input wire logic [7:0] COL_DIR_OUT,
    input wire logic [7:0] COL_IN,
    input wire logic [7:0] COL_OUT,
    input wire logic [7:0] COL_OE,
    input wire logic [7:0] ROW_OUT,
    input wire logic [7:0] ROW_OE,
    input wire logic [7:0] PORT_INPUT,
    input wire logic [7:0] FADE_LEVEL,
    input wire logic TIMEOUT_IRQ,
    input wire logic PORT_RUN,
    input wire logic DEVICE_SHUTDOWN,
    input wire logic PORT_REG_RESET
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_irq_has_cause: assert property ($rose(TIMEOUT_IRQ) |-> $past(BUS_TIMEOUT) ||
        $past(BUS_TIMEOUT, 2)) else $error("irq rose without timeout");
    a_irq_read_clear: assert property (REG_RD && REG_ADDR == ADDR_TMO_FLAG && !BUS_TIMEOUT
        ##1 !BUS_TIMEOUT |-> ##[1:2] !TIMEOUT_IRQ) else $error("irq not cleared by read");
    a_shutdown_sleep: assert property ($past(ARST_N) |->
        DEVICE_SHUTDOWN == (!PORT_RUN && $past(SLEEP_MODE))) else $error("shutdown wrong");
    a_port_rst_pulse: assert property (REG_WR && REG_ADDR == ADDR_GLOBAL_CFG &&
        REG_WDATA[CFG_PORT_RST_BIT] |=> PORT_REG_RESET ##1 !PORT_REG_RESET)
        else $error("port reset pulse wrong");
    a_fade_off_idle: assert property (!PORT_RUN [*3] |-> FADE_LEVEL == 8'h00)
        else $error("fade level while stopped");
    a_input_held_off: assert property (!PORT_RUN [*3] |-> $stable(PORT_INPUT))
        else $error("input moved while stopped");
    a_col_oe_dir: assert property ((COL_OE & ~$past(COL_DIR_OUT)) == 8'h00)
        else $error("column driven while input");
    a_upper_open_drain: assert property (COL_OUT[7:4] == 4'h0)
        else $error("upper column driven high");
    a_row_follow_col: assert property (((ROW_OUT ^ $past(COL_IN)) & ROW_OE) == 8'h00)
        else $error("row not following column");
endmodule
bind gpgc_top gpgc_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .BUS_TIMEOUT(BUS_TIMEOUT),
    .SLEEP_MODE(SLEEP_MODE), .COL_DIR_OUT(COL_DIR_OUT), .COL_IN(COL_IN), .COL_OUT(COL_OUT),
    .COL_OE(COL_OE), .ROW_OUT(ROW_OUT), .ROW_OE(ROW_OE), .PORT_INPUT(PORT_INPUT),
    .FADE_LEVEL(FADE_LEVEL), .TIMEOUT_IRQ(TIMEOUT_IRQ), .PORT_RUN(PORT_RUN),
    .DEVICE_SHUTDOWN(DEVICE_SHUTDOWN), .PORT_REG_RESET(PORT_REG_RESET));

/* File: gpgc_host.sv */
// Purpose: host side of the register port.
// Assumes: strobes one cycle, driven after the rising edge.
// Notes: released address and data show the inverse.
module gpgc_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic bus_timeout
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_wr, reg_rd, bus_timeout, reg_addr, reg_wdata} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b0, ~a};
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic tmo();
        @(posedge clk);
        bus_timeout <= 1'b1;
        @(posedge clk);
        bus_timeout <= 1'b0;
    endtask
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench of port global control.
// Assumes: MS_CYCLES of 10 shortens every millisecond count.
// Notes: stimulus from an lfsr seeded with 81.
module testbench
    import gpgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, wr, rd, tmo, sleep, on, irq, run, shut, prst;
    logic [7:0] addr, wdata, rdata, pwm, dir, pp, cin, rin, cout, coe, rout, roe, pin, lvl;
    logic [7:0] v, r, s, cv;
    logic [7:0] ra[5] = '{ADDR_COL_VALUES, ADDR_SHIFT_EN, ADDR_GLOBAL_CFG, ADDR_DEBOUNCE, 8'h20};
    logic [7:0] re[5] = '{RST_COL_VALUES, RST_SHIFT_EN, RST_GLOBAL_CFG, RST_DEBOUNCE, 8'h00};
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    gpgc_host u_gpgc_host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .bus_timeout(tmo));
    gpgc_top #(.MS_CYCLES(10)) u_gpgc_top (.CLK(clk), .ARST_N(arst_n), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .BUS_TIMEOUT(tmo),
        .SLEEP_MODE(sleep), .COMMON_PWM(pwm), .FADE_TARGET_ON(on), .COL_DIR_OUT(dir),
        .COL_PUSH_PULL(pp), .COL_IN(cin), .COL_OUT(cout), .COL_OE(coe), .ROW_IN(rin),
        .ROW_OUT(rout), .ROW_OE(roe), .PORT_INPUT(pin), .FADE_LEVEL(lvl), .TIMEOUT_IRQ(irq),
        .PORT_RUN(run), .DEVICE_SHUTDOWN(shut), .PORT_REG_RESET(prst));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic complete_run();
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures = failures + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] q);
        return {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
    endfunction
    // column drive: shifted row value or register value; upper four open-drain
    function automatic logic [7:0] exp_oe(input logic [7:0] val, input logic [7:0] m);
        return dir & ((m & 8'h0f) | ~val);
    endfunction
    // level after ms milliseconds of ramping up from zero with fade code c
    function automatic logic [7:0] exp_fade(input int c, input int ms);
        int st;
        st = ms / (16 << (c - 1));
        return (st >= 16) ? pwm : 8'((pwm * st) >> 4);
    endfunction
    task automatic regs_por();
        foreach (ra[i]) begin
            u_gpgc_host.rd(ra[i], v);
            chk(v, re[i]);
        end
    endtask
    task automatic fade_to(input logic t, input int n, input logic [7:0] e);
        on <= t;
        repeat (n) @(posedge clk);
        chk(lvl, e);
    endtask
    initial begin
        {arst_n, sleep, on, pwm, dir, pp, cin, rin} = {3'b000, 8'h80, 32'h0};
        r = 8'h51;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        regs_por();
        u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h10);
        repeat (8) begin
            r = lfsr(r);
            s = lfsr(r);
            cv = r ^ 8'h3c;
            {dir, pp, rin, cin} <= {s, r, ~r, s ^ r};
            u_gpgc_host.wr(ADDR_DEBOUNCE, r);
            u_gpgc_host.rd(ADDR_DEBOUNCE, v);
            chk(v, r & 8'h1f);
            u_gpgc_host.wr(ADDR_GLOBAL_CFG, (r & 8'hd7) | 8'h10);
            u_gpgc_host.rd(ADDR_GLOBAL_CFG, v);
            chk(v, (r & 8'h17) | 8'h10);
            u_gpgc_host.wr(ADDR_COL_VALUES, cv);
            u_gpgc_host.wr(ADDR_SHIFT_EN, s);
            repeat (2) @(posedge clk);
            v = (s & rin) | (~s & cv);
            chk(coe, exp_oe(v, pp));
            chk(cout & dir, dir & v & pp & 8'h0f);
            chk(roe, s & ~dir);
            chk(rout & roe, cin & s & ~dir);
        end
        u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h00);
        u_gpgc_host.wr(ADDR_SHIFT_EN, ~s);
        chk(coe, exp_oe(v, pp));
        u_gpgc_host.rd(ADDR_SHIFT_EN, v);
        chk(v, s);
        chk({7'h0, run}, 8'h00);
        chk(lvl, 8'h00);
        sleep <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h0, shut}, 8'h01);
        u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h10);
        repeat (3) @(posedge clk);
        chk({6'h0, shut, run}, 8'h01);
        sleep <= 1'b0;
        u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h18);
        @(posedge clk);
        chk({7'h0, prst}, 8'h01);
        regs_por();
        u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h30);
        u_gpgc_host.tmo();
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        for (int k = 1; k >= 0; k--) begin
            u_gpgc_host.rd(ADDR_TMO_FLAG, v);
            chk(v, k[7:0]);
        end
        chk({7'h0, irq}, 8'h00);
        u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h10);
        u_gpgc_host.tmo();
        u_gpgc_host.rd(ADDR_TMO_FLAG, v);
        chk(v, 8'h00);
        u_gpgc_host.wr(ADDR_DEBOUNCE, 8'h00);
        cin <= 8'h00;
        repeat (300) @(posedge clk);
        cin <= 8'h01;
        repeat (75) @(posedge clk);
        chk(pin, 8'h00);
        repeat (40) @(posedge clk);
        chk(pin, 8'h01);
        u_gpgc_host.wr(ADDR_DEBOUNCE, 8'h1f);
        cin <= 8'h00;
        repeat (375) @(posedge clk);
        chk(pin, 8'h01);
        repeat (60) @(posedge clk);
        chk(pin, 8'h00);
        fade_to(1'b1, 6, pwm);
        fade_to(1'b0, 6, 8'h00);
        for (int c = 1; c <= 2; c++) begin
            u_gpgc_host.wr(ADDR_GLOBAL_CFG, 8'h10 | c[7:0]);
            fade_to(1'b1, (2560 << (c - 1)) - 200, exp_fade(c, (256 << (c - 1)) - 20));
            fade_to(1'b1, 400, pwm);
            fade_to(1'b0, (2560 << (c - 1)) + 200, 8'h00);
        end
        complete_run();
    end
endmodule
